// ===== inc/sleep_ctrl_pkg.sv
// Purpose: shared constants and types for the sleep and reset controller
// Assumes: one 200 MHz clock, asynchronous active-high reset
// Notes:   sleep mode codes follow the software select field
package sleep_ctrl_pkg;

	// ********************************
	// clock and timing
	// ********************************
	localparam int CLK_PERIOD_PS        = 5000;
	// minimum low time of the external reset pin, in ns
	localparam int RESET_PULSE_MIN_NS   = 2500;
	localparam int RESET_PULSE_CYCLES   = (RESET_PULSE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// cycles the gated clocks run before the cpu fetches again
	localparam int WAKE_SETTLE_CYCLES   = 4;
	// oscillator start-up time after power-down, in ns
	localparam int OSC_START_NS         = 1000;
	localparam int OSC_START_CYCLES     = (OSC_START_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// ********************************
	// port widths
	// ********************************
	localparam int PORT_B_W             = 8;
	localparam int PORT_C_W             = 7;
	localparam int PORT_D_W             = 8;
	localparam int PORT_C_RESET_BIT     = 6;
	localparam int PORT_B_OSC_ONE_BIT   = 6;
	localparam int PORT_B_OSC_TWO_BIT   = 7;

	// ********************************
	// sleep mode select codes
	// ********************************
	localparam logic [2:0] MODE_IDLE      = 3'h0;
	localparam logic [2:0] MODE_ADC_NR    = 3'h1;
	localparam logic [2:0] MODE_PWR_DOWN  = 3'h2;
	localparam logic [2:0] MODE_PWR_SAVE  = 3'h3;
	localparam logic [2:0] MODE_STANDBY   = 3'h6;

	// clock domain gate enables, one bit per domain
	localparam int DOM_CPU   = 0;
	localparam int DOM_SRAM  = 1;
	localparam int DOM_TIMER = 2;
	localparam int DOM_SER   = 3;
	localparam int DOM_ADC   = 4;
	localparam int DOM_IRQ   = 5;
	localparam int DOM_OSC   = 6;
	localparam int DOM_ASYNC = 7;
	localparam int DOM_W     = 8;
	localparam logic [7:0] DOM_ALL_ON = 8'hff;

	// one-hot controller states
	typedef enum logic [3:0] {
		ST_RUN   = 4'h1,
		ST_SLEEP = 4'h2,
		ST_OSC   = 4'h4,
		ST_WAKE  = 4'h8
	} sleep_state_t;

endpackage

// ===== verilog/reset_pin_filter.sv
// Purpose: qualifies the external reset pin by a minimum low time
// Assumes: pin already synchronous to clk; low means reset
// Notes:   needs the clock to count; only rst acts with no clock running
`timescale 1ns/1ps
module reset_pin_filter
	import sleep_ctrl_pkg::*;
#(
	parameter int PULSE_CYCLES = RESET_PULSE_CYCLES
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic pin_low,
	output logic      pulse_ok
);
	// the low-time counter is 16 bits wide; larger counts would wrap
	if (PULSE_CYCLES < 1 || PULSE_CYCLES > 65535) begin : g_bad_pulse
		$error("PULSE_CYCLES out of range");
	end

	typedef struct packed {
		logic [15:0] cnt;
		logic        ok;
	} filt_t;

	filt_t filt_reg;
	filt_t filt_next;

	// count low time; shorter pulses are dropped
	always_comb begin
		filt_next = filt_reg;
		if (!pin_low) begin
			filt_next.cnt = 16'h0000;
			filt_next.ok  = 1'b0;
		end else if (filt_reg.cnt >= 16'(PULSE_CYCLES - 1)) begin
			filt_next.ok = 1'b1;
		end else begin
			filt_next.cnt = filt_reg.cnt + 16'h0001;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			filt_reg <= '0;
		end else begin
			filt_reg <= filt_next;
		end
	end

	assign pulse_ok = filt_reg.ok;
endmodule

// ===== verilog/domain_gate_decode.sv
// Purpose: turns a sleep mode into a registered set of domain enables
// Assumes: mode is stable while asleep is high
// Notes:   unknown mode codes fall back to idle behaviour
`timescale 1ns/1ps
module domain_gate_decode
	import sleep_ctrl_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic               asleep,
	input  wire logic               osc_hold,
	input  wire logic [2:0]         mode,
	output logic      [DOM_W-1:0]   dom_en
);
	typedef struct packed {
		logic [DOM_W-1:0] en;
	} gate_t;

	gate_t gate_reg;
	gate_t gate_next;

	// which domains stay alive in a mode
	function automatic logic [DOM_W-1:0] mode_domains(input logic [2:0] m);
		logic [DOM_W-1:0] d;
		d = '0;
		d[DOM_ASYNC] = 1'b1;
		case (m)
			MODE_ADC_NR: begin
				d[DOM_ADC] = 1'b1;
				d[DOM_OSC] = 1'b1;
			end
			MODE_PWR_DOWN: begin
				d[DOM_ASYNC] = 1'b0;
			end
			MODE_PWR_SAVE: begin
				d[DOM_ASYNC] = 1'b1;
			end
			MODE_STANDBY: begin
				d[DOM_ASYNC] = 1'b0;
				d[DOM_OSC]   = 1'b1;
			end
			default: begin
				d = DOM_ALL_ON;
				d[DOM_CPU] = 1'b0;
			end
		endcase
		return d;
	endfunction

	// osc_hold keeps the cpu gated while the clocks restart
	always_comb begin
		gate_next.en = DOM_ALL_ON;
		if (asleep) begin
			gate_next.en = mode_domains(mode);
		end else if (osc_hold) begin
			gate_next.en = DOM_ALL_ON;
			gate_next.en[DOM_CPU] = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gate_reg.en <= DOM_ALL_ON;
		end else begin
			gate_reg <= gate_next;
		end
	end

	assign dom_en = gate_reg.en;
endmodule

// ===== verilog/sleep_reset_ctrl.sv
// Purpose: sleep mode sequencing, port reset tri-state and reset pin use
// Assumes: inputs synchronous to clk; rst is power-on / brown-out reset
// Notes:   no software registers; controls and fuses are plain pins
//          the pin reset needs the clock to qualify its low time
//
// Functional notes
// - five software-selected sleep modes gate domains
// - idle stops only the cpu clock
// - power-down freezes oscillator, keeps state
// - power-down exits on interrupt or reset
// - power-save keeps asynchronous timer counting
// - adc noise reduction keeps adc, async timer
// - standby keeps oscillator running for fast wake
// - reset tri-states ports b, c, d clocklessly
// - fuse unprogrammed makes port c six reset
// - long enough low pin pulse forces reset
// - rc clock plus select routes timer oscillator
`timescale 1ns/1ps
module sleep_reset_ctrl
	import sleep_ctrl_pkg::*;
#(
	parameter int PULSE_CYCLES = RESET_PULSE_CYCLES,
	parameter int OSC_CYCLES   = OSC_START_CYCLES,
	parameter int SETTLE       = WAKE_SETTLE_CYCLES
) (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst,

	// sleep control from the core
	input  wire logic                 sleep_req,
	input  wire logic                 sleep_enable,
	input  wire logic [2:0]           sleep_mode,
	input  wire logic                 irq_wake,

	// fuse and clock source selection
	input  wire logic                 reset_pin_disable_fuse,
	input  wire logic                 rc_osc_selected,
	input  wire logic                 async_timer_clock_select,

	// pin levels seen at the pads
	input  wire logic [PORT_B_W-1:0]  port_b_in,
	input  wire logic [PORT_C_W-1:0]  port_c_in,

	// port data and drive requests from the core
	input  wire logic [PORT_B_W-1:0]  port_b_out_core,
	input  wire logic [PORT_B_W-1:0]  port_b_drive_core,
	input  wire logic [PORT_C_W-1:0]  port_c_out_core,
	input  wire logic [PORT_C_W-1:0]  port_c_drive_core,
	input  wire logic [PORT_D_W-1:0]  port_d_out_core,
	input  wire logic [PORT_D_W-1:0]  port_d_drive_core,

	// port pins, oe_n low drives the pad
	output logic      [PORT_B_W-1:0]  port_b_o,
	output logic      [PORT_B_W-1:0]  port_b_oe_n,
	output logic      [PORT_C_W-1:0]  port_c_o,
	output logic      [PORT_C_W-1:0]  port_c_oe_n,
	output logic      [PORT_D_W-1:0]  port_d_o,
	output logic      [PORT_D_W-1:0]  port_d_oe_n,

	// clock gating, fetch and reset
	output logic      [DOM_W-1:0]     domain_enable,
	output logic                      cpu_fetch_enable,
	output logic                      device_reset,

	// timer oscillator and status
	output logic                      timer_osc_input_one,
	output logic                      timer_osc_input_two,
	output logic                      timer_osc_active,
	output logic                      sleeping
);

	// ********************************
	// parameter checks
	// ********************************
	// the wake counter is 16 bits wide; larger counts would wrap
	if (OSC_CYCLES < 1 || OSC_CYCLES > 65535) begin : g_bad_osc
		$error("OSC_CYCLES out of range");
	end
	if (SETTLE < 1 || SETTLE > 65535) begin : g_bad_settle
		$error("SETTLE out of range");
	end

	// ********************************
	// external reset pin
	// ********************************
	// raw low level of the pin and its qualified version
	logic pin_reset_low;
	logic pin_reset_ok;

	// pin acts as reset only while the fuse is unprogrammed
	assign pin_reset_low = !reset_pin_disable_fuse && !port_c_in[PORT_C_RESET_BIT];

	// the filter owns the low-time count; the top sees a plain level
	reset_pin_filter #(
		.PULSE_CYCLES (PULSE_CYCLES)
	) u_filter (
		.clk      (clk),
		.rst      (rst),
		.pin_low  (pin_reset_low),
		.pulse_ok (pin_reset_ok)
	);

	// ********************************
	// controller state
	// ********************************
	// all controller state in one struct, so reset and next value stay in step
	typedef struct packed {
		sleep_state_t         st;
		logic [2:0]           mode;
		logic [15:0]          cnt;
		logic                 fetch;
		logic                 rst_out;
		logic                 osc_one;
		logic                 osc_two;
		logic                 tosc_on;
		logic                 slp;
		logic [PORT_B_W-1:0]  b_o;
		logic [PORT_B_W-1:0]  b_oe_n;
		logic [PORT_C_W-1:0]  c_o;
		logic [PORT_C_W-1:0]  c_oe_n;
		logic [PORT_D_W-1:0]  d_o;
		logic [PORT_D_W-1:0]  d_oe_n;
	} ctrl_t;

	ctrl_t ctrl_reg;
	ctrl_t ctrl_next;

	// ********************************
	// clock gating
	// ********************************
	logic osc_hold;
	logic [DOM_W-1:0] dom_en;

	// cpu stays gated from sleep until the settle count expires
	assign osc_hold = (ctrl_reg.st == ST_OSC) || (ctrl_reg.st == ST_WAKE);

	// the decoder registers its enables, so gating lags the state by one edge
	domain_gate_decode u_gate (
		.clk      (clk),
		.rst      (rst),
		.asleep   (ctrl_reg.st == ST_SLEEP),
		.osc_hold (osc_hold),
		.mode     (ctrl_reg.mode),
		.dom_en   (dom_en)
	);

	// ********************************
	// wake helpers
	// ********************************
	// modes that stop the main oscillator need a start-up wait
	// standby keeps the crystal running, so it skips the wait
	function automatic logic osc_stopped(input logic [2:0] m);
		return (m == MODE_PWR_DOWN) || (m == MODE_PWR_SAVE);
	endfunction

	// ********************************
	// next-state logic
	// ********************************
	// run -> sleep on a request while sleep is enabled
	// sleep -> osc on an interrupt when the mode froze the oscillator
	// sleep -> wake on an interrupt in every other mode
	// osc -> wake after the oscillator start-up count
	// wake -> run after the settle count; fetch returns one edge before the cpu domain clock
	// a qualified pin reset drops any state back to run, fetch held
	// rst is the clockless path; the pin reset lands on clock edges
	// because its low time can only be counted with the clock
	// the cpu domain stays gated from one edge after sleep entry until one edge after fetch returns
	// port drivers follow the core one edge late outside reset
	always_comb begin
		ctrl_next = ctrl_reg;
		// device_reset follows the qualified pin one edge late
		ctrl_next.rst_out = pin_reset_ok;

		case (ctrl_reg.st)
			ST_RUN: begin
				ctrl_next.fetch = 1'b1;
				// a request without sleep_enable is dropped with no sign
				if (sleep_req && sleep_enable) begin
					ctrl_next.st    = ST_SLEEP;
					ctrl_next.mode  = sleep_mode;
					ctrl_next.fetch = 1'b0;
				end
			end
			ST_SLEEP: begin
				ctrl_next.fetch = 1'b0;
				// only an interrupt wakes; reset restarts everything
				// mode was latched at entry; later sleep_mode changes are ignored
				if (irq_wake) begin
					ctrl_next.cnt = 16'h0000;
					if (osc_stopped(ctrl_reg.mode)) begin
						ctrl_next.st = ST_OSC;
					end else begin
						ctrl_next.st = ST_WAKE;
					end
				end
			end
			ST_OSC: begin
				// oscillator was frozen; wait for it to start
				// the cpu stays gated; only the clocks restart
				if (ctrl_reg.cnt >= 16'(OSC_CYCLES - 1)) begin
					ctrl_next.cnt = 16'h0000;
					ctrl_next.st  = ST_WAKE;
				end else begin
					ctrl_next.cnt = ctrl_reg.cnt + 16'h0001;
				end
			end
			ST_WAKE: begin
				// clocks already running; fetch waits the settle time
				// the settle count lets the restarted domains run first
				if (ctrl_reg.cnt >= 16'(SETTLE - 1)) begin
					ctrl_next.cnt   = 16'h0000;
					ctrl_next.st    = ST_RUN;
					ctrl_next.fetch = 1'b1;
				end else begin
					ctrl_next.cnt = ctrl_reg.cnt + 16'h0001;
				end
			end
			default: begin
				// an illegal state code recovers to run
				ctrl_next.st = ST_RUN;
			end
		endcase

		// pin reset returns the controller to run with fetch held
		if (pin_reset_ok) begin
			ctrl_next.st    = ST_RUN;
			ctrl_next.fetch = 1'b0;
			ctrl_next.cnt   = 16'h0000;
		end

		// sleeping is a flop of its own, so the port needs no decode
		ctrl_next.slp = (ctrl_next.st == ST_SLEEP);

		// timer oscillator pins, only with rc clock and select set
		ctrl_next.tosc_on = rc_osc_selected && async_timer_clock_select;
		ctrl_next.osc_one = ctrl_next.tosc_on && port_b_in[PORT_B_OSC_ONE_BIT];
		ctrl_next.osc_two = ctrl_next.tosc_on && port_b_in[PORT_B_OSC_TWO_BIT];

		// port drivers follow the core; a pin reset floats them
		ctrl_next.b_o    = port_b_out_core;
		ctrl_next.b_oe_n = ~port_b_drive_core;
		ctrl_next.c_o    = port_c_out_core;
		ctrl_next.c_oe_n = ~port_c_drive_core;
		ctrl_next.d_o    = port_d_out_core;
		ctrl_next.d_oe_n = ~port_d_drive_core;
		// released pins keep the port drivers off the crystal
		if (ctrl_next.tosc_on) begin
			ctrl_next.b_oe_n[PORT_B_OSC_ONE_BIT] = 1'b1;
			ctrl_next.b_oe_n[PORT_B_OSC_TWO_BIT] = 1'b1;
		end
		if (!reset_pin_disable_fuse) begin
			ctrl_next.c_oe_n[PORT_C_RESET_BIT] = 1'b1;
		end
		if (pin_reset_ok) begin
			ctrl_next.b_oe_n = '1;
			ctrl_next.c_oe_n = '1;
			ctrl_next.d_oe_n = '1;
		end
	end

	// ********************************
	// state register
	// ********************************
	// async reset puts every port enable high with no clock needed
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			// other fields clear: data low, fetch held, counters zero
			ctrl_reg         <= '0;
			ctrl_reg.st      <= ST_RUN;
			ctrl_reg.mode    <= MODE_IDLE;
			ctrl_reg.rst_out <= 1'b1;
			ctrl_reg.b_oe_n  <= '1;
			ctrl_reg.c_oe_n  <= '1;
			ctrl_reg.d_oe_n  <= '1;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	// ********************************
	// outputs
	// ********************************
	// every output is a flop, no logic behind the pins
	// port pins
	assign port_b_o            = ctrl_reg.b_o;
	assign port_b_oe_n         = ctrl_reg.b_oe_n;
	assign port_c_o            = ctrl_reg.c_o;
	assign port_c_oe_n         = ctrl_reg.c_oe_n;
	assign port_d_o            = ctrl_reg.d_o;
	assign port_d_oe_n         = ctrl_reg.d_oe_n;

	// clock gating, fetch and reset
	assign domain_enable       = dom_en;
	assign cpu_fetch_enable    = ctrl_reg.fetch;
	assign device_reset        = ctrl_reg.rst_out;

	// timer oscillator routing
	assign timer_osc_input_one = ctrl_reg.osc_one;
	assign timer_osc_input_two = ctrl_reg.osc_two;
	assign timer_osc_active    = ctrl_reg.tosc_on;

	// status
	assign sleeping            = ctrl_reg.slp;
endmodule

// ===== sim/sleep_reset_ctrl_props.sv
// Purpose: port-level checks on the sleep and reset controller
// Assumes: one clock domain, rst async active high
// Notes:   sleep_mode is held stable while asleep
`timescale 1ns/1ps
module sleep_reset_ctrl_props
	import sleep_ctrl_pkg::*;
(
	input wire logic                clk,
	input wire logic                rst,
	input wire logic                sleep_req,
	input wire logic                sleep_enable,
	input wire logic [2:0]          sleep_mode,
	input wire logic                irq_wake,
	input wire logic                rc_osc_selected,
	input wire logic                async_timer_clock_select,
	input wire logic [PORT_B_W-1:0] port_b_in,
	input wire logic [PORT_B_W-1:0] port_b_oe_n,
	input wire logic [PORT_C_W-1:0] port_c_oe_n,
	input wire logic [PORT_D_W-1:0] port_d_oe_n,
	input wire logic [DOM_W-1:0]    domain_enable,
	input wire logic                cpu_fetch_enable,
	input wire logic                device_reset,
	input wire logic                timer_osc_input_one,
	input wire logic                timer_osc_input_two,
	input wire logic                timer_osc_active,
	input wire logic                sleeping
);
	// ****
	// sequences
	// ****
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// gating lags sleep entry by one edge, so wait a cycle
	sequence s_held(logic [2:0] m);
		sleeping && $past(sleeping) && sleep_mode == m;
	endsequence
	sequence s_wake;
		sleeping && irq_wake;
	endsequence
	// ****
	// properties
	// ****
	a_sleep_taken: assert property (
		cpu_fetch_enable && !sleeping && !device_reset && sleep_req && sleep_enable |=> sleeping && !cpu_fetch_enable)
		else $error("sleep request not taken");
	a_idle_gates: assert property (s_held(MODE_IDLE) |-> (domain_enable & 8'h2f) == 8'h2e)
		else $error("idle gating wrong");
	a_adc_gates: assert property (s_held(MODE_ADC_NR) |-> (domain_enable & 8'h9d) == 8'h90)
		else $error("adc noise gating wrong");
	a_pdown_gates: assert property (s_held(MODE_PWR_DOWN) |-> domain_enable == 8'h00)
		else $error("power-down gating wrong");
	a_psave_gates: assert property (s_held(MODE_PWR_SAVE) |-> domain_enable == 8'h80)
		else $error("power-save gating wrong");
	a_standby_osc: assert property (s_held(MODE_STANDBY) |-> domain_enable == 8'h40)
		else $error("standby gating wrong");
	a_sleep_holds: assert property (sleeping && !irq_wake && !device_reset |=> sleeping)
		else $error("left sleep without wake");
	a_wake_bound: assert property (s_wake |=> !sleeping ##[1:300] $rose(cpu_fetch_enable))
		else $error("wake did not resume fetch");
	a_clocks_first: assert property (
		$rose(cpu_fetch_enable) |-> domain_enable[7:1] == 7'h7f && $past(domain_enable[7:1]) == 7'h7f)
		else $error("fetch before clocks ran");
	a_reset_tristate: assert property (
		device_reset |-> &port_b_oe_n && &port_c_oe_n && &port_d_oe_n)
		else $error("port driven in reset");
	a_tosc_route: assert property (
		rc_osc_selected && async_timer_clock_select |=> timer_osc_active
		&& timer_osc_input_one == $past(port_b_in[PORT_B_OSC_ONE_BIT])
		&& timer_osc_input_two == $past(port_b_in[PORT_B_OSC_TWO_BIT]))
		else $error("timer oscillator routing wrong");
endmodule

bind sleep_reset_ctrl sleep_reset_ctrl_props props_i (.clk, .rst, .sleep_req, .sleep_enable, .sleep_mode,
	.irq_wake, .rc_osc_selected, .async_timer_clock_select, .port_b_in, .port_b_oe_n, .port_c_oe_n,
	.port_d_oe_n, .domain_enable, .cpu_fetch_enable, .device_reset, .timer_osc_input_one,
	.timer_osc_input_two, .timer_osc_active, .sleeping);

// ===== sim/tb_sleep_reset_ctrl.sv
// Purpose: self-checking bench for the sleep and reset controller
// Assumes: short filter, oscillator and settle counts
// Notes:   inputs change on the falling edge only
`timescale 1ns/1ps
module tb_sleep_reset_ctrl
	import sleep_ctrl_pkg::*;
;
	localparam int PC = 4;
	logic               clk = 1'b0;
	logic               rst, sleep_req, sleep_enable, irq_wake, reset_pin_disable_fuse;
	logic               rc_osc_selected, async_timer_clock_select, cpu_fetch_enable, device_reset;
	logic               timer_osc_input_one, timer_osc_input_two, timer_osc_active, sleeping;
	logic [2:0]         sleep_mode;
	logic [7:0]         port_b_in, port_b_out_core, port_b_drive_core, port_d_out_core, port_d_drive_core;
	logic [7:0]         port_b_o, port_b_oe_n, port_d_o, port_d_oe_n, domain_enable;
	logic [6:0]         port_c_in, port_c_out_core, port_c_drive_core, port_c_o, port_c_oe_n;
	int                 n_mismatch = 0;
	int                 tests_run = 0;
	int                 n, t_idle, t_pd;

	// ****
	// clock and design
	// ****
	always #2.5 clk = ~clk;
	sleep_reset_ctrl #(.PULSE_CYCLES(PC), .OSC_CYCLES(3), .SETTLE(4)) uut (.clk, .rst, .sleep_req,
		.sleep_enable, .sleep_mode, .irq_wake, .reset_pin_disable_fuse, .rc_osc_selected,
		.async_timer_clock_select, .port_b_in, .port_c_in, .port_b_out_core, .port_b_drive_core,
		.port_c_out_core, .port_c_drive_core, .port_d_out_core, .port_d_drive_core, .port_b_o,
		.port_b_oe_n, .port_c_o, .port_c_oe_n, .port_d_o, .port_d_oe_n, .domain_enable,
		.cpu_fetch_enable, .device_reset, .timer_osc_input_one, .timer_osc_input_two,
		.timer_osc_active, .sleeping);

	// ****
	// helpers
	// ****
	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask
	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ****
	// scenarios
	// ****
	task automatic t_reset;
		cyc(1);
		chk("reset oe b", 8'hff, port_b_oe_n);
		chk("reset oe c", 8'h7f, {1'b0, port_c_oe_n});
		chk("reset oe d", 8'hff, port_d_oe_n);
		chk("reset flag", 1, device_reset);
		chk("reset fetch", 0, cpu_fetch_enable);
		chk("reset clocks", 8'hff, domain_enable);
		cyc(2);
		rst = 1'b0;
		cyc(3);
		chk("run fetch", 1, cpu_fetch_enable);
		chk("reset released", 0, device_reset);
		chk("port b data", 8'h3c, port_b_o);
		chk("port c data", 8'h2a, {1'b0, port_c_o});
		chk("port c drive", 8'h40, {1'b0, port_c_oe_n});
		chk("port d data", 8'h3c, port_d_o);
		chk("port d drive", 8'h5a, port_d_oe_n);
	endtask
	// request with sleep disabled must be ignored
	task automatic t_refuse;
		sleep_enable = 1'b0;
		sleep_req = 1'b1;
		cyc(3);
		sleep_req = 1'b0;
		sleep_enable = 1'b1;
		cyc(1);
		chk("refused sleep", 0, sleeping);
		chk("fetch kept", 1, cpu_fetch_enable);
	endtask
	// sleep in mode m, check gating under mask, wake and time it
	task automatic t_sleep(input logic [2:0] m, input logic [7:0] e, input logic [7:0] k, output int w);
		sleep_mode = m;
		sleep_req = 1'b1;
		cyc(1);
		sleep_req = 1'b0;
		chk("asleep", 1, sleeping);
		chk("fetch off", 0, cpu_fetch_enable);
		cyc(20);
		chk("gated domains", e & k, domain_enable & k);
		chk("still asleep", 1, sleeping);
		irq_wake = 1'b1;
		w = 0;
		do begin
			cyc(1);
			irq_wake = 1'b0;
			w++;
		end while (cpu_fetch_enable !== 1'b1 && w < 100);
		chk("wake fetch", 1, cpu_fetch_enable);
		chk("clocks before fetch", 8'h7f, {1'b0, domain_enable[7:1]});
		cyc(2);
		chk("all clocks", 8'hff, domain_enable);
	endtask
	// hold the reset pin low for len cycles
	task automatic t_pin(input logic f, input int len, input logic e);
		reset_pin_disable_fuse = f;
		port_c_in[PORT_C_RESET_BIT] = 1'b0;
		cyc(len);
		chk("pin reset", e, device_reset);
		chk("port b tristate", e ? 8'hff : 8'h5a, port_b_oe_n);
		chk("port c tristate", e ? 8'h7f : (f ? 8'h00 : 8'h40), {1'b0, port_c_oe_n});
		port_c_in[PORT_C_RESET_BIT] = 1'b1;
		cyc(8);
		chk("reset over", 1, cpu_fetch_enable);
	endtask
	task automatic t_tosc;
		{rc_osc_selected, async_timer_clock_select} = 2'h3;
		port_b_in = 8'h40;
		cyc(2);
		chk("tosc one", 1, timer_osc_input_one);
		chk("tosc pins float", 8'hda, port_b_oe_n);
		chk("tosc two", 0, timer_osc_input_two);
		port_b_in = 8'h80;
		cyc(2);
		chk("tosc two high", 1, timer_osc_input_two);
		async_timer_clock_select = 1'b0;
		cyc(2);
		chk("tosc off", 0, timer_osc_active);
	endtask

	// ****
	// main sequence
	// ****
	initial begin
		{rst, sleep_enable, reset_pin_disable_fuse} = 3'h6;
		{sleep_req, irq_wake, rc_osc_selected, async_timer_clock_select} = 4'h0;
		{sleep_mode, port_b_in, port_c_in} = {3'h0, 8'h00, 7'h7f};
		{port_b_out_core, port_b_drive_core, port_d_out_core, port_d_drive_core} = 32'h3ca53ca5;
		{port_c_out_core, port_c_drive_core} = 14'h157f;
		t_reset();
		t_refuse();
		t_sleep(MODE_IDLE, 8'h2e, 8'h2f, t_idle);
		t_sleep(MODE_ADC_NR, 8'h90, 8'h9d, n);
		t_sleep(MODE_PWR_DOWN, 8'h00, 8'hff, t_pd);
		t_sleep(MODE_PWR_SAVE, 8'h80, 8'hff, n);
		t_sleep(MODE_STANDBY, 8'h40, 8'hff, n);
		chk("standby fast wake", 1, {7'h0, n == t_idle && n < t_pd});
		t_sleep(3'h4, 8'hfe, 8'hff, n);
		t_pin(1'b0, PC + 4, 1'b1);
		t_pin(1'b0, PC - 2, 1'b0);
		t_pin(1'b1, PC + 4, 1'b0);
		t_tosc();
		tally_and_finish();
	end
	// the run needs about 230 cycles; give it far more
	initial begin
		#10000;
		n_mismatch++;
		tally_and_finish();
	end
endmodule
